// file: logic/prog_entry_pkg.sv
// constants and types shared by the programming-mode entry logic
package prog_entry_pkg;
    localparam int          KEY_WIDTH      = 32;
    // key value is arbitrary; the real key is defined elsewhere
    localparam logic [31:0] ENTRY_KEY      = 32'h5a5a_c3c3;
    localparam int          FRAME_WIDTH    = 16;
    localparam int          BUF_DEPTH      = 2;
    localparam logic        LVE_RESET_VAL  = 1'b1;
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_LV_KEY,
        MODE_LV_PROG,
        MODE_HV_PROG
    } prog_mode_t;
endpackage

// file: logic/word_buffer.sv
// two-entry valid/ready buffer for received program words
`timescale 1ns/10ps
module word_buffer
    import prog_entry_pkg::*;
#(
    parameter int WIDTH = FRAME_WIDTH
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    if (WIDTH < 1) begin : g_bad_width
        $error("word_buffer: WIDTH must be positive");
    end

    logic [WIDTH-1:0] mem_r [BUF_DEPTH];
    logic             wr_ptr_r;
    logic             rd_ptr_r;
    logic [1:0]       count_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count_r != 2'd2);
    assign out_valid = (count_r != 2'd0);
    assign out_data  = mem_r[rd_ptr_r];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'd0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= in_data;
                wr_ptr_r        <= ~wr_ptr_r;
            end
            if (pop) rd_ptr_r <= ~rd_ptr_r;
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // word_buffer

// file: logic/serial_program_entry.sv
// programming-mode entry detector and serial word receiver
`timescale 1ns/10ps
module serial_program_entry
    import prog_entry_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // programmer pins
    input  wire logic                   prog_serial_clock,
    input  wire logic                   prog_serial_data_in,
    output logic                        prog_serial_data_out,
    output logic                        prog_serial_data_oe,
    input  wire logic                   ext_reset_pin_low,
    input  wire logic                   high_entry_level,
    // configuration
    input  wire logic                   cfg_reset_enable,
    input  wire logic                   clear_lve_req,
    output logic                        low_voltage_entry_enable,
    output logic                        reset_function_on,
    // mode status
    output logic                        prog_mode_active,
    output logic                        hv_mode_active,
    // verify readback to shift out
    input  wire logic                   rd_load,
    input  wire logic [FRAME_WIDTH-1:0] rd_word,
    // received words
    output logic                        word_valid,
    input  wire logic                   word_ready,
    output logic      [FRAME_WIDTH-1:0] word_data
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] clk_s_r, dat_s_r, rst_s_r, hv_s_r;
    logic       sclk_d_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_s_r  <= 2'b00;
            dat_s_r  <= 2'b00;
            rst_s_r  <= 2'b00;
            hv_s_r   <= 2'b00;
            sclk_d_r <= 1'b0;
        end else begin
            clk_s_r  <= {clk_s_r[0], prog_serial_clock};
            dat_s_r  <= {dat_s_r[0], prog_serial_data_in};
            rst_s_r  <= {rst_s_r[0], ext_reset_pin_low};
            hv_s_r   <= {hv_s_r[0], high_entry_level};
            sclk_d_r <= clk_s_r[1];
        end
    end
    wire sclk      = clk_s_r[1];
    wire sdat      = dat_s_r[1];
    wire rst_low   = rst_s_r[1];
    wire hv_level  = hv_s_r[1];
    wire sclk_rise = sclk && !sclk_d_r;
    wire sclk_fall = !sclk && sclk_d_r;

    // ------------------------------------------------------------
    // mode control
    // ------------------------------------------------------------
    prog_mode_t       mode_r, mode_nxt;
    logic [31:0]      key_r;
    logic [5:0]       key_cnt_r;
    logic             lve_r;
    logic             hv_armed_r;
    wire [31:0] key_next = {key_r[30:0], sdat};
    wire key_done     = (key_cnt_r == 6'(KEY_WIDTH - 1)) && sclk_rise;
    wire key_match    = (key_next == ENTRY_KEY);
    wire hv_entry     = hv_level && hv_armed_r;

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            MODE_IDLE: begin
                if (hv_entry) mode_nxt = MODE_HV_PROG;
                else if (rst_low && lve_r) mode_nxt = MODE_LV_KEY;
            end
            MODE_LV_KEY: begin
                if (!rst_low) mode_nxt = MODE_IDLE;
                else if (key_done) begin
                    mode_nxt = key_match ? MODE_LV_PROG : MODE_IDLE;
                end
            end
            MODE_LV_PROG: if (!rst_low) mode_nxt = MODE_IDLE;
            MODE_HV_PROG: if (!hv_level) mode_nxt = MODE_IDLE;
            default: mode_nxt = MODE_IDLE;
        endcase
    end

    // failed key waits for reset release before retrying
    logic key_fail_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r     <= MODE_IDLE;
            hv_armed_r <= 1'b0;
            key_fail_r <= 1'b0;
        end else begin
            mode_r     <= (key_fail_r && mode_nxt == MODE_LV_KEY)
                          ? MODE_IDLE : mode_nxt;
            hv_armed_r <= !sclk && !sdat && !hv_level;
            if (!rst_low) key_fail_r <= 1'b0;
            else if (mode_r == MODE_LV_KEY && key_done && !key_match)
                key_fail_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_r     <= '0;
            key_cnt_r <= '0;
        end else if (mode_r != MODE_LV_KEY || !rst_low) begin
            key_r     <= '0;
            key_cnt_r <= '0;
        end else if (sclk_rise) begin
            key_r     <= key_next;
            key_cnt_r <= key_cnt_r + 6'd1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) lve_r <= LVE_RESET_VAL;
        else if (clear_lve_req && mode_r == MODE_HV_PROG) lve_r <= 1'b0;
    end
    assign low_voltage_entry_enable = lve_r;
    assign reset_function_on = lve_r || cfg_reset_enable;
    assign prog_mode_active  = (mode_r == MODE_LV_PROG)
                               || (mode_r == MODE_HV_PROG);
    assign hv_mode_active    = (mode_r == MODE_HV_PROG);

    // ------------------------------------------------------------
    // serial data transfers
    // ------------------------------------------------------------
    logic [FRAME_WIDTH-1:0] rx_r, tx_r;
    logic [4:0]             bit_cnt_r;
    logic                   rx_valid_r, tx_act_r, oe_r;
    logic                   buf_ready;
    // ignores incoming bits while the buffer is full, so they are lost
    wire rx_bit = prog_mode_active && sclk_rise && !tx_act_r && buf_ready;
    wire rx_end = rx_bit && (bit_cnt_r == 5'(FRAME_WIDTH - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_r       <= '0;
            bit_cnt_r  <= '0;
            rx_valid_r <= 1'b0;
            tx_r       <= '0;
            tx_act_r   <= 1'b0;
            oe_r       <= 1'b0;
        end else if (!prog_mode_active) begin
            bit_cnt_r  <= '0;
            rx_valid_r <= 1'b0;
            tx_act_r   <= 1'b0;
            oe_r       <= 1'b0;
        end else begin
            rx_valid_r <= rx_end;
            if (rx_bit) begin
                rx_r      <= {sdat, rx_r[FRAME_WIDTH-1:1]};
                bit_cnt_r <= rx_end ? 5'd0 : bit_cnt_r + 5'd1;
            end
            if (rd_load && !tx_act_r) begin
                tx_r      <= rd_word;
                tx_act_r  <= 1'b1;
                bit_cnt_r <= '0;
            end else if (tx_act_r && sclk_fall) begin
                oe_r <= 1'b1;
                if (oe_r) tx_r <= {1'b0, tx_r[FRAME_WIDTH-1:1]};
                if (oe_r && bit_cnt_r == 5'(FRAME_WIDTH - 1)) begin
                    tx_act_r  <= 1'b0;
                    oe_r      <= 1'b0;
                    bit_cnt_r <= '0;
                end else if (oe_r) bit_cnt_r <= bit_cnt_r + 5'd1;
            end
        end
    end
    assign prog_serial_data_out = tx_r[0];
    assign prog_serial_data_oe  = oe_r;

    word_buffer #(.WIDTH(FRAME_WIDTH)) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (rx_valid_r),
        .in_ready  (buf_ready),
        .in_data   (rx_r),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_lv_needs_enable;
        @(posedge clk) disable iff (!rst_n)
        !lve_r |-> mode_r != MODE_LV_KEY && mode_r != MODE_LV_PROG;
    endproperty
    a_lv_needs_enable: assert property (p_lv_needs_enable)
        else $error("low-voltage entry without enable bit");

    property p_lve_clear_hv;
        @(posedge clk) disable iff (!rst_n)
        $fell(lve_r) |-> $past(mode_r) == MODE_HV_PROG;
    endproperty
    a_lve_clear_hv: assert property (p_lve_clear_hv)
        else $error("enable bit cleared outside high-voltage mode");

    property p_reset_forced;
        @(posedge clk) disable iff (!rst_n)
        lve_r |-> reset_function_on;
    endproperty
    a_reset_forced: assert property (p_reset_forced)
        else $error("reset function off while enable bit set");

    property p_lv_exit;
        @(posedge clk) disable iff (!rst_n)
        (mode_r == MODE_LV_PROG && !rst_low) |=> mode_r == MODE_IDLE;
    endproperty
    a_lv_exit: assert property (p_lv_exit)
        else $error("low-voltage mode kept after reset release");

    property p_key_match;
        @(posedge clk) disable iff (!rst_n)
        $rose(mode_r == MODE_LV_PROG)
            |-> key_r == ENTRY_KEY && key_cnt_r == 6'(KEY_WIDTH);
    endproperty
    a_key_match: assert property (p_key_match)
        else $error("program mode entered without key match");

    property p_key_clear;
        @(posedge clk) disable iff (!rst_n)
        !rst_low |=> key_cnt_r == 6'd0;
    endproperty
    a_key_clear: assert property (p_key_clear)
        else $error("partial key kept after reset release");

    property p_hv_entry;
        @(posedge clk) disable iff (!rst_n)
        (mode_r == MODE_IDLE && hv_entry) |=> mode_r == MODE_HV_PROG;
    endproperty
    a_hv_entry: assert property (p_hv_entry)
        else $error("high-voltage entry not taken");

    property p_oe_in_mode;
        @(posedge clk) disable iff (!rst_n)
        prog_serial_data_oe |-> $past(prog_mode_active);
    endproperty
    a_oe_in_mode: assert property (p_oe_in_mode)
        else $error("data pin driven outside program mode");

    property p_rx_word;
        @(posedge clk) disable iff (!rst_n)
        rx_end |=> rx_valid_r;
    endproperty
    a_rx_word: assert property (p_rx_word)
        else $error("received word not presented");

    c_hv: cover property (@(posedge clk) mode_r == MODE_HV_PROG);
    c_lv: cover property (@(posedge clk) mode_r == MODE_LV_PROG);
    c_word: cover property (@(posedge clk) word_valid && word_ready);
    c_full: cover property (@(posedge clk) !buf_ready);
endmodule // serial_program_entry

// file: sim/prog_host_model.sv
// programmer-side model driving the serial entry pins
`timescale 1ns/10ps
module prog_host_model (
    // pins towards the device
    output logic      pclk,
    output logic      dat,
    output logic      rst_low,
    output logic      hv_level,
    // resolved data line
    input  wire logic dat_wire
);
    localparam realtime HALF = 62.5;
    // --------------------------------------------
    // pin sequences
    // --------------------------------------------
    // clock only ever driven here
    initial begin
        pclk = 1'b0;
        dat = 1'b0;
        rst_low = 1'b0;
        hv_level = 1'b0;
    end
    task automatic shift_bit(input logic b);
        dat = b;
        #HALF pclk = 1'b1;
        #HALF pclk = 1'b0;
    endtask
    // key msb first, clock idles low
    task automatic send_key(input logic [31:0] k);
        for (int i = 31; i >= 0; i--) shift_bit(k[i]);
        // released line must not keep its last level
        dat = ~dat;
    endtask
    task automatic send_word(input logic [15:0] w);
        for (int i = 0; i < 16; i++) shift_bit(w[i]);
        dat = ~dat;
    endtask
    task automatic read_word(output logic [15:0] w);
        for (int i = 0; i < 16; i++) begin
            pclk = 1'b1;
            #HALF pclk = 1'b0;
            #HALF w[i] = dat_wire;
        end
        // one more falling edge ends the device's drive
        pclk = 1'b1;
        #HALF pclk = 1'b0;
        #HALF;
    endtask
    // reset pin held low for the session
    task automatic set_reset_low(input logic v);
        rst_low = v;
        #HALF;
    endtask
    // clock and data low before high level
    task automatic hv_enter();
        pclk = 1'b0;
        dat = 1'b0;
        #HALF rst_low = 1'b0;
        hv_level = 1'b1;
    endtask
    task automatic hv_exit();
        hv_level = 1'b0;
        #HALF;
    endtask
endmodule // prog_host_model

// file: sim/serial_program_entry_tb.sv
// self-checking bench for the programming-mode entry logic
`timescale 1ns/10ps
module serial_program_entry_tb
    import prog_entry_pkg::*;
;
    logic                   clk, rst_n, cfg_reset_enable, clear_lve_req;
    logic                   rd_load, word_ready, word_valid;
    logic                   pclk, hdat, rst_low, hv_level, data_out;
    logic                   data_oe, lve, rst_fn, prog_act, hv_act;
    logic [FRAME_WIDTH-1:0] rd_word, word_data, got;
    logic [31:0]            seed;
    logic [15:0]            exp_q[$];
    wire                    data_wire;
    int                     bad_count, n_checks;

    assign data_wire = data_oe ? data_out : hdat;
    initial clk = 1'b0;
    always #5 clk = ~clk;

    prog_host_model host (.pclk(pclk), .dat(hdat), .rst_low(rst_low),
        .hv_level(hv_level), .dat_wire(data_wire));
    serial_program_entry uut (.clk(clk), .rst_n(rst_n),
        .prog_serial_clock(pclk), .prog_serial_data_in(data_wire),
        .prog_serial_data_out(data_out), .prog_serial_data_oe(data_oe),
        .ext_reset_pin_low(rst_low), .high_entry_level(hv_level),
        .cfg_reset_enable(cfg_reset_enable), .clear_lve_req(clear_lve_req),
        .low_voltage_entry_enable(lve), .reset_function_on(rst_fn),
        .prog_mode_active(prog_act), .hv_mode_active(hv_act),
        .rd_load(rd_load), .rd_word(rd_word), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data));
    // --------------------------------------------
    // checking helpers
    // --------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction
    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk16(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_modes(input logic p, input logic h, input logic l);
        chk1("prog_mode_active", p, prog_act);
        chk1("hv_mode_active", h, hv_act);
        chk1("low_voltage_entry_enable", l, lve);
    endtask
    // covers pin synchroniser latency and edge detect
    task automatic settle();
        repeat (12) @(posedge clk);
    endtask
    task automatic pulse_clear();
        @(posedge clk) clear_lve_req <= 1'b1;
        @(posedge clk) clear_lve_req <= 1'b0;
        settle();
    endtask
    // consumer stalls at random while draining
    task automatic drain();
        for (int n = 0; n < 200 && exp_q.size() > 0; n++) begin
            @(negedge clk);
            if (word_valid === 1'b1 && word_ready === 1'b1)
                chk16("word_data", exp_q.pop_front(), word_data);
            @(posedge clk);
            seed = lfsr(seed);
            word_ready <= seed[0];
        end
        chk1("drained", 1'b1, exp_q.size() == 0);
        settle();
        chk1("word_valid", 1'b0, word_valid);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // --------------------------------------------
    // scenarios
    // --------------------------------------------
    initial begin
        rst_n = 1'b0;
        cfg_reset_enable = 1'b0;
        clear_lve_req = 1'b0;
        rd_load = 1'b0;
        rd_word = 16'h0000;
        word_ready = 1'b0;
        seed = 32'h0001_5fa4;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        chk_modes(1'b0, 1'b0, 1'b1);
        chk1("reset_function_on", 1'b1, rst_fn);
        host.set_reset_low(1'b1);
        host.send_key(ENTRY_KEY ^ 32'h0000_0001);
        settle();
        chk_modes(1'b0, 1'b0, 1'b1);
        host.set_reset_low(1'b0);
        settle();
        host.set_reset_low(1'b1);
        host.send_key(ENTRY_KEY);
        settle();
        chk_modes(1'b1, 1'b0, 1'b1);
        // third word meets a full buffer and is lost
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            host.send_word(seed[15:0]);
            if (exp_q.size() < BUF_DEPTH) exp_q.push_back(seed[15:0]);
        end
        settle();
        drain();
        seed = lfsr(seed);
        @(posedge clk);
        rd_load <= 1'b1;
        rd_word <= seed[15:0];
        @(posedge clk) rd_load <= 1'b0;
        host.read_word(got);
        chk16("readback", seed[15:0], got);
        settle();
        chk1("prog_serial_data_oe", 1'b0, data_oe);
        pulse_clear();
        chk_modes(1'b1, 1'b0, 1'b1);
        host.set_reset_low(1'b0);
        settle();
        chk_modes(1'b0, 1'b0, 1'b1);
        host.hv_enter();
        settle();
        chk_modes(1'b1, 1'b1, 1'b1);
        chk1("reset_function_on", 1'b1, rst_fn);
        pulse_clear();
        chk_modes(1'b1, 1'b1, 1'b0);
        chk1("reset_function_on", 1'b0, rst_fn);
        @(posedge clk) cfg_reset_enable <= 1'b1;
        settle();
        chk1("reset_function_on", 1'b1, rst_fn);
        host.hv_exit();
        settle();
        chk_modes(1'b0, 1'b0, 1'b0);
        host.set_reset_low(1'b1);
        host.send_key(ENTRY_KEY);
        settle();
        chk_modes(1'b0, 1'b0, 1'b0);
        complete_run();
    end
    // hang guard, far beyond the expected run
    initial begin
        #500_000;
        bad_count++;
        complete_run();
    end
endmodule // serial_program_entry_tb
